//--- opt_pkg.sv
// opt_pkg: constants, encodings and carrier types of the operand type decoder
// assumes a 32-bit classic wishbone bus with byte addresses, one word a register
package opt_pkg;
	// descriptor encodings
	localparam logic [3:0] OVR_MARK       = 4'hE;
	localparam logic [3:0] MODE_ABS_DEFER = 4'hE;
	localparam logic [3:0] REG_IMM        = 4'hF;
	localparam logic [7:0] ABS_DEFER      = {MODE_ABS_DEFER, REG_IMM};
	localparam logic [3:0] MODE_LIT_MAX   = 4'h3;
	localparam logic [3:0] MODE_NEG_LIT   = 4'hF;
	localparam logic [3:0] MODE_IMM32     = 4'h4;
	localparam logic [3:0] MODE_IMM16     = 4'h5;
	localparam logic [3:0] MODE_IMM8      = 4'h6;
	// override type codes
	localparam logic [3:0] TC_SBYTE = 4'h7;
	localparam logic [3:0] TC_SHALF = 4'h6;
	localparam logic [3:0] TC_SWORD = 4'h4;
	localparam logic [3:0] TC_UBYTE = 4'h3;
	localparam logic [3:0] TC_UHALF = 4'h2;
	localparam logic [3:0] TC_UWORD = 4'h0;
	// word variants of opcode families, low two bits give the size
	localparam logic [7:0] OP_COPY_32BIT  = 8'h84;
	localparam logic [7:0] OP_COPY_EADDR  = 8'h04;
	localparam logic [7:0] OP_MCOM_W      = 8'h88;
	localparam logic [7:0] OP_MNEG_W      = 8'h8C;
	localparam logic [7:0] OP_ADD_W2      = 8'h9C;
	localparam logic [7:0] OP_ADD_W3      = 8'hDC;
	localparam logic [7:0] OP_SUB_W2      = 8'hBC;
	localparam logic [7:0] OP_SUB_W3      = 8'hFC;
	localparam logic [7:0] OP_INC_W       = 8'h90;
	localparam logic [7:0] OP_DEC_W       = 8'h94;
	localparam logic [7:0] OP_MUL_W2      = 8'hA8;
	localparam logic [7:0] OP_DIV_W2      = 8'hAC;
	localparam logic [7:0] OP_XCHG_W      = 8'h1C;
	localparam logic [1:0] SZV_BYTE       = 2'h3;
	localparam logic [1:0] SZV_HALF       = 2'h2;
	localparam logic [15:0] OP_STRING_COPY = 16'h3035;
	localparam logic [15:0] OP_STRING_END  = 16'h301F;
	// call, save, restore, stack push/pop, subroutine jump, coprocessor
	localparam logic [9:0][15:0] NO_OVR_OPS = {16'h002C, 16'h0010, 16'h0018, 16'h00A0,
		16'h00E0, 16'h0020, 16'h0034, 16'h0002, 16'h0006, 16'h0022};
	// execution cycle counts
	localparam logic [31:0] EXEC_BASE_CYC = 32'h3;
	localparam logic [31:0] MULDIV_CYC    = 32'h20;
	localparam logic [31:0] EARLY_CYC     = 32'h2;
	localparam logic [31:0] STR_BASE_CYC  = 32'h4;
	localparam logic [31:0] STR_BYTE_CYC  = 32'h2;
	// register byte offsets
	localparam logic [7:0] REG_OPCODE = 8'h00;
	localparam logic [7:0] REG_DESC   = 8'h04;
	localparam logic [7:0] REG_OPND0  = 8'h08;
	localparam logic [7:0] REG_OPND1  = 8'h0C;
	localparam logic [7:0] REG_OPND2  = 8'h10;
	localparam logic [7:0] REG_STRLEN = 8'h14;
	localparam logic [7:0] REG_EXEC   = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_RESULT = 8'h20;
	localparam logic [7:0] REG_SLOTS  = 8'h24;
	// types
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} opt_size_t;
	typedef enum logic [3:0] {ALU_PASS, ALU_NOT, ALU_NEG, ALU_ADD, ALU_SUB,
		ALU_INC, ALU_DEC, ALU_MUL, ALU_DIV} opt_alu_op_t;
	typedef struct packed {
		logic      sgn;
		opt_size_t size;
	} opt_type_t;
	typedef struct packed {
		logic      valid;
		logic      imm;
		logic      lit;
		logic      absdef;
		opt_type_t ty;
	} opt_slot_t;
	typedef struct packed {
		logic [17:0] pad;
		logic [1:0]  nslot;
		logic [3:0]  flags;
		opt_type_t   ovr;
		logic        ovr_on;
		logic        pending;
		logic        ovf;
		logic        fault;
		logic        busy;
	} opt_status_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} opt_wb_t;
endpackage

//--- opt_ext.sv
// opt_ext: widens a raw operand to 32 bits by its operand type
// assumes the type comes from the decoder's slot or destination type
`timescale 1ns/1ps
`default_nettype none
module opt_ext
	import opt_pkg::*;
(
	// raw value and its type
	input  wire logic [31:0] i_raw,
	input  wire opt_type_t   i_ty,
	// widened value
	output logic      [31:0] o_val
);
	// sign or zero extension from the type's width
	always_comb begin
		case (i_ty.size)
			SZ_BYTE: o_val = {{24{i_ty.sgn & i_raw[7]}}, i_raw[7:0]};
			SZ_HALF: o_val = {{16{i_ty.sgn & i_raw[15]}}, i_raw[15:0]};
			default: o_val = i_raw;
		endcase
	end
endmodule
`default_nettype wire

//--- opt_alu.sv
// opt_alu: 32-bit arithmetic for copy, add, subtract, multiply, divide
// assumes operands already widened; x is the first operand, y the second
`timescale 1ns/1ps
`default_nettype none
module opt_alu
	import opt_pkg::*;
(
	// operation and operands
	input  wire opt_alu_op_t i_op,
	input  wire logic [31:0] i_x,
	input  wire logic [31:0] i_y,
	// result, low 32 bits only
	output logic      [31:0] o_res,
	output logic             o_ovf,
	output logic             o_carry
);
	logic [32:0] sum;
	logic [63:0] prod;
	// one operation per cycle, overflow judged on signed 32-bit range or a zero divisor
	always_comb begin
		sum = {1'b0, i_y} + {1'b0, i_x};
		prod = $signed({{32{i_x[31]}}, i_x}) * $signed({{32{i_y[31]}}, i_y});
		o_res = i_x;
		o_ovf = 1'b0;
		o_carry = 1'b0;
		case (i_op)
			ALU_NOT: o_res = ~i_x;
			ALU_NEG: begin
				o_res = 32'h0 - i_x;
				o_ovf = (i_x == 32'h80000000);
			end
			ALU_ADD: begin
				o_res = sum[31:0];
				o_carry = sum[32];
				o_ovf = (i_x[31] == i_y[31]) && (sum[31] != i_x[31]);
			end
			ALU_SUB: begin
				sum = {1'b0, i_y} - {1'b0, i_x};
				o_res = sum[31:0];
				o_carry = sum[32];
				o_ovf = (i_x[31] != i_y[31]) && (sum[31] != i_y[31]);
			end
			ALU_INC: begin
				o_res = i_x + 32'h1;
				o_ovf = (i_x == 32'h7FFFFFFF);
			end
			ALU_DEC: begin
				o_res = i_x - 32'h1;
				o_ovf = (i_x == 32'h80000000);
			end
			ALU_MUL: begin
				o_res = prod[31:0];
				o_ovf = (prod[63:32] != {32{prod[31]}});
			end
			ALU_DIV: begin
				o_res = (i_x == 32'h0) ? 32'h0 : 32'($signed(i_y) / $signed(i_x));
				o_ovf = (i_x == 32'h0) || (i_y == 32'h80000000 && i_x == 32'hFFFFFFFF);
			end
			default: o_res = i_x;
		endcase
	end
endmodule
`default_nettype wire

//--- opt_decoder.sv
// opt_decoder: operand type decoder and executor behind a wishbone slave
// assumes a classic wishbone master on i_clk that holds each request until ack
`timescale 1ns/1ps
`default_nettype none
module opt_decoder
	import opt_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// wishbone request
	input  wire opt_wb_t     i_wb,
	// wishbone answer
	output logic             o_wb_ack,
	output logic      [31:0] o_wb_dat,
	// status levels
	output logic             o_busy,
	output logic             o_fault,
	output logic             o_ovf
);
	typedef enum logic {DS_FIRST, DS_SECOND} opt_dstate_t;
	typedef enum logic {EX_IDLE, EX_RUN} opt_xstate_t;
	typedef struct packed {
		logic              ack;
		logic       [31:0] rdat;
		logic       [15:0] opcode;
		opt_dstate_t       dst;
		logic              ovr_on;
		opt_type_t         ovr;
		logic        [1:0] nslot;
		opt_slot_t   [2:0] slot;
		logic [2:0] [31:0] opnd;
		logic       [31:0] strlen;
		opt_xstate_t       xst;
		logic       [31:0] cnt;
		logic       [31:0] result;
		logic        [3:0] flags;
		logic              fault;
		logic              ovf;
	} opt_state_t;

	opt_state_t        st_q;
	opt_state_t        st_d;
	logic              bus_req;
	logic              wr;
	logic              desc_wr;
	logic              exec_go;
	logic        [7:0] b;
	logic        [7:0] opw;
	logic              is_marker;
	logic              code_valid;
	opt_type_t         code_ty;
	opt_type_t         dflt_ty;
	opt_slot_t         new_slot;
	opt_slot_t         last_slot;
	logic        [9:0] no_ovr_hit;
	logic              op_no_ovr;
	opt_alu_op_t       alu_op;
	logic              one_opnd;
	logic              three_opnd;
	opt_type_t         dst_ty;
	logic [2:0] [31:0] ext_val;
	logic       [31:0] res_raw;
	logic       [31:0] res_trunc;
	logic              alu_ovf;
	logic              alu_c;
	logic              neg_flag;
	logic              is_str;
	logic              is_mdw2;
	logic              early;
	logic       [31:0] rd_mux;
	opt_status_t       stat;

	// byte-lane merge for partial writes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			wmerge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// bus qualifiers: a write lands on the edge where ack is seen
	assign bus_req = i_wb.cyc & i_wb.stb;
	assign wr      = bus_req & i_wb.we & st_q.ack;
	assign desc_wr = wr && (i_wb.adr == REG_DESC) && i_wb.sel[0];
	assign exec_go = wr && (i_wb.adr == REG_EXEC) && (st_q.xst == EX_IDLE) && !st_q.fault;
	assign b       = i_wb.dat[7:0];
	assign opw     = {st_q.opcode[7:2], 2'h0};
	assign is_marker = (b[7:4] == OVR_MARK) && (b != ABS_DEFER);

	// override type code decode
	always_comb begin
		code_valid = 1'b1;
		code_ty = '{sgn: 1'b0, size: SZ_WORD};
		case (b[3:0])
			TC_SBYTE: code_ty = '{sgn: 1'b1, size: SZ_BYTE};
			TC_SHALF: code_ty = '{sgn: 1'b1, size: SZ_HALF};
			TC_SWORD: code_ty = '{sgn: 1'b1, size: SZ_WORD};
			TC_UBYTE: code_ty = '{sgn: 1'b0, size: SZ_BYTE};
			TC_UHALF: code_ty = '{sgn: 1'b0, size: SZ_HALF};
			TC_UWORD: code_ty = '{sgn: 1'b0, size: SZ_WORD};
			default:  code_valid = 1'b0;
		endcase
	end

	// opcode size variant gives the default type: bytes unsigned, others signed
	always_comb begin
		case (st_q.opcode[1:0])
			SZV_BYTE: dflt_ty = '{sgn: 1'b0, size: SZ_BYTE};
			SZV_HALF: dflt_ty = '{sgn: 1'b1, size: SZ_HALF};
			default:  dflt_ty = '{sgn: 1'b1, size: SZ_WORD};
		endcase
	end

	// opcodes on which an override is illegal
	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_forbid
			assign no_ovr_hit[g] = (st_q.opcode == NO_OVR_OPS[g]);
		end
	endgenerate
	assign op_no_ovr = (|no_ovr_hit) || (st_q.opcode == {8'h00, OP_XCHG_W} ||
		st_q.opcode == {8'h00, OP_XCHG_W | {6'h0, SZV_HALF}} ||
		st_q.opcode == {8'h00, OP_XCHG_W | {6'h0, SZV_BYTE}});

	// slot built from an ordinary address-mode descriptor
	always_comb begin
		new_slot = '0;
		new_slot.valid = 1'b1;
		new_slot.absdef = (b == ABS_DEFER);
		new_slot.ty = st_q.ovr_on ? st_q.ovr : dflt_ty;
		if (b[7:4] <= MODE_LIT_MAX || b[7:4] == MODE_NEG_LIT) begin
			new_slot.lit = 1'b1;
			new_slot.ty = dflt_ty;
		end else if (b[3:0] == REG_IMM && (b[7:4] == MODE_IMM32 || b[7:4] == MODE_IMM16 ||
			b[7:4] == MODE_IMM8)) begin
			new_slot.imm = 1'b1;
			new_slot.ty.sgn = st_q.ovr_on ? st_q.ovr.sgn : dflt_ty.sgn;
			case (b[7:4])
				MODE_IMM8:  new_slot.ty.size = SZ_BYTE;
				MODE_IMM16: new_slot.ty.size = SZ_HALF;
				default:    new_slot.ty.size = SZ_WORD;
			endcase
		end
	end
	assign last_slot = st_q.slot[st_q.nslot - 2'h1];

	// opcode family decode
	always_comb begin
		alu_op = ALU_PASS;
		one_opnd = 1'b0;
		three_opnd = 1'b0;
		if (st_q.opcode[15:8] == 8'h00) begin
			case (opw)
				OP_COPY_32BIT, OP_COPY_EADDR: alu_op = ALU_PASS;
				OP_MCOM_W: alu_op = ALU_NOT;
				OP_MNEG_W: alu_op = ALU_NEG;
				OP_ADD_W2: alu_op = ALU_ADD;
				OP_ADD_W3: begin
					alu_op = ALU_ADD;
					three_opnd = 1'b1;
				end
				OP_SUB_W2: alu_op = ALU_SUB;
				OP_SUB_W3: begin
					alu_op = ALU_SUB;
					three_opnd = 1'b1;
				end
				OP_INC_W: begin
					alu_op = ALU_INC;
					one_opnd = 1'b1;
				end
				OP_DEC_W: begin
					alu_op = ALU_DEC;
					one_opnd = 1'b1;
				end
				OP_MUL_W2: alu_op = ALU_MUL;
				OP_DIV_W2: alu_op = ALU_DIV;
				default:   alu_op = ALU_PASS;
			endcase
		end
	end
	// destination is slot 0, 1 or 2 by operand count
	assign dst_ty = one_opnd ? st_q.slot[0].ty : (three_opnd ? st_q.slot[2].ty :
		st_q.slot[1].ty);

	// every source widened by its own slot type
	generate
		for (g = 0; g < 3; g++) begin : g_ext
			opt_ext u_ext (
				.i_raw (st_q.opnd[g]),
				.i_ty  (st_q.slot[g].ty),
				.o_val (ext_val[g])
			);
		end
	endgenerate

	opt_alu u_alu (
		.i_op    (alu_op),
		.i_x     (ext_val[0]),
		.i_y     (ext_val[1]),
		.o_res   (res_raw),
		.o_ovf   (alu_ovf),
		.o_carry (alu_c)
	);

	// result cut to the destination type
	opt_ext u_trunc (
		.i_raw (res_raw),
		.i_ty  (dst_ty),
		.o_val (res_trunc)
	);

	// sign of the destination-sized value
	always_comb begin
		case (dst_ty.size)
			SZ_BYTE: neg_flag = res_trunc[7];
			SZ_HALF: neg_flag = res_trunc[15];
			default: neg_flag = res_trunc[31];
		endcase
	end

	// timing classes
	assign is_str  = (st_q.opcode == OP_STRING_COPY) || (st_q.opcode == OP_STRING_END);
	assign is_mdw2 = (st_q.opcode == {8'h00, OP_MUL_W2}) || (st_q.opcode == {8'h00, OP_DIV_W2});
	assign early   = (ext_val[0] <= 32'h1) || (ext_val[1] <= 32'h1);

	// status word and read mux
	always_comb begin
		stat = '0;
		stat.busy = (st_q.xst == EX_RUN);
		stat.fault = st_q.fault;
		stat.ovf = st_q.ovf;
		stat.pending = (st_q.dst == DS_SECOND);
		stat.ovr_on = st_q.ovr_on;
		stat.ovr = st_q.ovr;
		stat.flags = st_q.flags;
		stat.nslot = st_q.nslot;
		case (i_wb.adr)
			REG_OPCODE: rd_mux = {16'h0, st_q.opcode};
			REG_DESC:   rd_mux = stat;
			REG_OPND0:  rd_mux = st_q.opnd[0];
			REG_OPND1:  rd_mux = st_q.opnd[1];
			REG_OPND2:  rd_mux = st_q.opnd[2];
			REG_STRLEN: rd_mux = st_q.strlen;
			REG_EXEC:   rd_mux = {31'h0, stat.busy};
			REG_STATUS: rd_mux = stat;
			REG_RESULT: rd_mux = st_q.result;
			REG_SLOTS:  rd_mux = {11'h0, st_q.slot};
			default:    rd_mux = 32'h0;
		endcase
	end

	// next state
	always_comb begin
		st_d = st_q;
		st_d.ack = bus_req & ~st_q.ack;
		if (bus_req & ~st_q.ack) begin
			st_d.rdat = rd_mux;
		end
		// execution countdown
		if (st_q.xst == EX_RUN) begin
			if (st_q.cnt <= 32'h1) begin
				st_d.xst = EX_IDLE;
				st_d.cnt = 32'h0;
			end else begin
				st_d.cnt = st_q.cnt - 32'h1;
			end
		end
		if (wr) begin
			case (i_wb.adr)
				REG_OPCODE: begin
					st_d.opcode = 16'(wmerge({16'h0, st_q.opcode}, i_wb.dat, i_wb.sel));
					st_d.dst = DS_FIRST;
					st_d.ovr_on = 1'b0;
					st_d.nslot = 2'h0;
					st_d.slot = '0;
					st_d.fault = 1'b0;
					st_d.ovf = 1'b0;
				end
				REG_DESC: begin
					if (i_wb.sel[0]) begin
						if (st_q.dst == DS_FIRST && is_marker) begin
							st_d.dst = DS_SECOND;
							st_d.ovr_on = 1'b1;
							st_d.ovr = code_ty;
							if (!code_valid || op_no_ovr) begin
								st_d.fault = 1'b1;
							end
						end else if (st_q.dst == DS_SECOND && is_marker) begin
							st_d.dst = DS_FIRST;
							st_d.fault = 1'b1;
						end else if (st_q.nslot == 2'h3) begin
							st_d.dst = DS_FIRST;
							st_d.fault = 1'b1;
						end else begin
							st_d.dst = DS_FIRST;
							st_d.slot[st_q.nslot] = new_slot;
							st_d.nslot = st_q.nslot + 2'h1;
						end
					end
				end
				REG_OPND0:  st_d.opnd[0] = wmerge(st_q.opnd[0], i_wb.dat, i_wb.sel);
				REG_OPND1:  st_d.opnd[1] = wmerge(st_q.opnd[1], i_wb.dat, i_wb.sel);
				REG_OPND2:  st_d.opnd[2] = wmerge(st_q.opnd[2], i_wb.dat, i_wb.sel);
				REG_STRLEN: st_d.strlen = wmerge(st_q.strlen, i_wb.dat, i_wb.sel);
				REG_EXEC: begin
					if (exec_go) begin
						st_d.xst = EX_RUN;
						st_d.result = res_trunc;
						st_d.flags = {neg_flag, res_trunc == 32'h0, alu_ovf, alu_c};
						if (alu_ovf) begin
							st_d.ovf = 1'b1;
						end
						if (is_str) begin
							st_d.cnt = STR_BASE_CYC + st_q.strlen * STR_BYTE_CYC;
						end else if (is_mdw2) begin
							st_d.cnt = early ? EARLY_CYC : MULDIV_CYC;
						end else begin
							st_d.cnt = EXEC_BASE_CYC;
						end
					end
				end
				default: st_d.xst = st_d.xst;
			endcase
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign o_wb_ack = st_q.ack;
	assign o_wb_dat = st_q.rdat;
	assign o_busy   = (st_q.xst == EX_RUN);
	assign o_fault  = st_q.fault;
	assign o_ovf    = st_q.ovf;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_NESTED_OVR: assert property (
		desc_wr && st_q.dst == DS_SECOND && is_marker |=> st_q.fault && st_q.dst == DS_FIRST)
		else $error("nested override not faulted");
	AST_RESERVED_TYPE: assert property (
		desc_wr && st_q.dst == DS_FIRST && is_marker && !code_valid |=> st_q.fault)
		else $error("reserved type code not faulted");
	AST_ABS_DEFER: assert property (
		desc_wr && st_q.dst == DS_FIRST && b == ABS_DEFER && st_q.nslot != 2'h3
		|=> st_q.dst == DS_FIRST && !stat.pending && last_slot.absdef)
		else $error("absolute deferred taken as override");
	AST_OVR_CARRIES: assert property (
		desc_wr && st_q.dst == DS_FIRST && !is_marker && st_q.ovr_on && !new_slot.lit &&
		!new_slot.imm && st_q.nslot != 2'h3 |=> last_slot.ty == $past(st_q.ovr))
		else $error("override type not carried forward");
	AST_NO_OVR_OPS: assert property (
		desc_wr && st_q.dst == DS_FIRST && is_marker && op_no_ovr |=> st_q.fault ##1 st_q.fault)
		else $error("override on forbidden opcode not faulted");
	AST_IMM_LEN: assert property (
		desc_wr && st_q.dst == DS_SECOND && b == {MODE_IMM8, REG_IMM} && st_q.nslot != 2'h3
		|=> last_slot.imm && last_slot.ty.size == SZ_BYTE && last_slot.ty.sgn == $past(st_q.ovr.sgn))
		else $error("immediate length changed by override");
	AST_DEFAULT_SIZE: assert property (
		desc_wr && st_q.dst == DS_FIRST && !is_marker && !st_q.ovr_on && !new_slot.imm &&
		st_q.nslot != 2'h3 && st_q.opcode[1:0] == 2'h3 |=> last_slot.ty.size == SZ_BYTE)
		else $error("byte opcode operand not byte sized");
	AST_OVF: assert property (
		exec_go && alu_ovf |=> st_q.ovf && st_q.result == $past(res_trunc))
		else $error("overflow not flagged");
	AST_STR_TIME: assert property (
		exec_go && is_str && st_q.strlen == 32'h1 |=> o_busy [*6] ##1 !o_busy)
		else $error("string op time wrong for length one");
	AST_EARLY: assert property (
		exec_go && is_mdw2 && ext_val[0] == 32'h0 |=> o_busy [*2] ##1 !o_busy)
		else $error("word multiply with zero not early");
	AST_TRUNC: assert property (
		exec_go && dst_ty == opt_type_t'{sgn: 1'b0, size: SZ_HALF} |=> st_q.result[31:16] == 16'h0)
		else $error("result not cut to unsigned halfword");

	COV_OVR_THEN_MODE: cover property (
		desc_wr && is_marker && st_q.dst == DS_FIRST ##[1:20] desc_wr && st_q.dst == DS_SECOND);
	COV_STRING: cover property (exec_go && is_str);
	COV_OVERFLOW: cover property (exec_go && alu_ovf);
	COV_EARLY: cover property (exec_go && is_mdw2 && early);
endmodule
`default_nettype wire

//--- opt_imem.sv
// opt_imem: instruction byte store standing in front of the decoder
// assumes the bench fills mem and steps i_addr one byte at a time
`timescale 1ns/1ps
`default_nettype none
module opt_imem (
	// byte address
	input  wire logic [7:0] i_addr,
	// byte at that address
	output logic      [7:0] o_byte
);
	logic [7:0] mem [256];
	// descriptor bytes follow each other in stream order
	assign o_byte = mem[i_addr];
endmodule
`default_nettype wire

//--- tb_operand_type_decoder.sv
// tb_operand_type_decoder: self-checking bench for opt_decoder
// assumes classic wishbone with ack one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module tb_operand_type_decoder;
	import opt_pkg::*;
	logic        clk;
	logic        rst_n;
	opt_wb_t     wb;
	logic        ack;
	logic [31:0] rd;
	logic        busy;
	logic        fault;
	logic        ovf;
	logic [7:0]  pc;
	logic [7:0]  ib;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] e;
	logic [31:0] s;
	int          num_errors;
	int          samples_checked;
	int          seed;
	int          n;
	int          t;
	logic [15:0] lo [4] = '{16'h84, 16'h86, 16'h84, 16'h84};
	logic [23:0] ds [4] = '{24'h4140E3, 24'h424140, 24'h056FE0, 24'h4F5F6F};
	logic [20:0] sx [4] = '{21'h002040, 21'h1162C5, 21'h002B60, 21'h19B2E4};
	logic [15:0] tops [8] = '{16'h3035, 16'h301F, 16'hA8, 16'hAC, 16'hA8, 16'hAB,
		16'h3035, 16'h301F};
	int          tcyc [8] = '{4, 6, 2, 2, 32, 3, 16, 18};

	opt_decoder u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb(wb), .o_wb_ack(ack),
		.o_wb_dat(rd), .o_busy(busy), .o_fault(fault), .o_ovf(ovf));
	opt_imem u_mem (.i_addr(pc), .o_byte(ib));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// verdict and end of run
	task automatic tally_and_finish;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// compare and count
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
		samples_checked++;
		if (x !== y) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, x, y);
		end
	endtask

	// one classic wishbone cycle, read data kept in s
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		@(posedge clk);
		wb <= '{1'b1, 1'b1, w, ad, 4'hF, d};
		k = 0;
		@(posedge clk);
		while (ack !== 1'b1) begin
			k++;
			if (k > 40) begin
				num_errors++;
				tally_and_finish;
			end
			@(posedge clk);
		end
		s = rd;
		wb.cyc <= 1'b0;
		wb.stb <= 1'b0;
	endtask

	// opcode then descriptor bytes fetched from the byte store
	task automatic ld(input logic [15:0] op, input logic [31:0] dv, input int nd);
		bus(1'b1, REG_OPCODE, {16'h0, op});
		for (int i = 0; i < nd; i++) begin
			u_mem.mem[i] = dv[8*i +: 8];
			pc = 8'(i);
			#1;
			bus(1'b1, REG_DESC, {24'h0, ib});
		end
	endtask

	// operands, start, and busy length in n
	task automatic run(input logic [31:0] x, input logic [31:0] y);
		bus(1'b1, REG_OPND0, x);
		bus(1'b1, REG_OPND1, y);
		bus(1'b1, REG_EXEC, 32'h1);
		n = 0;
		@(posedge clk);
		while (busy === 1'b1 && n < 2000) begin
			n++;
			@(posedge clk);
		end
	endtask

	// reference widening by sign and size
	function automatic logic [31:0] ext(input logic [31:0] v, input logic sg, input int sz);
		case (sz)
			0: return sg ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]};
			1: return sg ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
			default: return v;
		endcase
	endfunction

	// watchdog
	initial begin
		#200000;
		num_errors++;
		tally_and_finish;
	end

	// main sequence
	initial begin
		seed = 26226;
		num_errors = 0;
		samples_checked = 0;
		wb = '0;
		pc = 8'h00;
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 32'h0, s);
		// every override type code
		for (t = 0; t < 15; t++) begin
			ld(16'h0084, {16'h0, 8'h40, 4'hE, 4'(t)}, 2);
			e = (t == 1 || t == 5 || t > 7) ? 32'h1 : 32'h0;
			bus(1'b0, REG_STATUS, 32'h0);
			chk("fault", e, {31'h0, fault});
			if (e == 0) begin
				chk("type", {t[2], t[1:0] == 3 ? 2'h0 : t[1:0] == 2 ? 2'h1 : 2'h2, 1'b1}, s[7:4]);
			end
		end
		// absolute deferred is a plain descriptor
		ld(16'h0084, 32'hEF, 1);
		bus(1'b0, REG_STATUS, 32'h0);
		chk("ovr", 32'h0, s[4:3]);
		bus(1'b0, REG_SLOTS, 32'h0);
		chk("slot", 32'h4E, s[6:0]);
		ld(16'h0084, 32'hE3E7, 2);
		bus(1'b0, REG_STATUS, 32'h0);
		chk("nested", 32'h1, s[1]);
		// override on forbidden opcodes
		for (t = 0; t < 11; t++) begin
			ld(t < 10 ? NO_OVR_OPS[t] : 16'h001C, 32'h40E4, 2);
			bus(1'b0, REG_STATUS, 32'h0);
			chk("forbid", 32'h1, s[1]);
		end
		// slot types: carry, size variant, immediates, literals
		for (t = 0; t < 4; t++) begin
			ld(lo[t], {8'h0, ds[t]}, 3);
			bus(1'b0, REG_SLOTS, 32'h0);
			chk("slots", sx[t], s[20:0]);
		end
		// signed byte source into unsigned halfword destination
		ld(16'h0087, 32'h41E240E7, 4);
		a = $random(seed);
		run(a, 32'h0);
		bus(1'b0, REG_RESULT, 32'h0);
		chk("result", ext(ext(a, 1'b1, 0), 1'b0, 1), s);
		// add in two and three operand forms
		for (t = 0; t < 8; t++) begin
			a = t[1] ? 32'h7FFFFFFF : $random(seed);
			b = (t == 4) ? -a : $random(seed);
			// positive addend on the largest word forces one overflow
			if (t == 2) begin
				b = {1'b0, b[30:1], 1'b1};
			end
			ld({8'h0, t[0] ? OP_ADD_W3 : OP_ADD_W2}, t[0] ? 32'h424140 : 32'h4140, 2 + t[0]);
			run(a, b);
			e = a + b;
			bus(1'b0, REG_STATUS, 32'h0);
			chk("nz", {e[31], e == 0}, s[11:10]);
			chk("ovf", a[31] == b[31] && e[31] != a[31], ovf);
			bus(1'b0, REG_RESULT, 32'h0);
			chk("sum", e, s);
		end
		// execution time by opcode, operands and string length
		for (t = 0; t < 8; t++) begin
			bus(1'b1, REG_STRLEN, 32'(t));
			ld(tops[t], 32'h4140, 2);
			a = $random(seed) | 32'h10;
			run(t == 2 ? 32'h1 : t == 3 ? 32'h0 : a, a);
			chk("busy", tcyc[t], n);
			if (t == 4 || t == 5) begin
				bus(1'b0, REG_RESULT, 32'h0);
				chk("product", t == 4 ? a * a : ext(a * a, 1'b0, 0), s);
			end
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
